/* File: pkg/hcv_pkg.sv */
// Package: offsets, field layout, reset values and types of the host controller version block.
// Assumes a 32-bit AHB-Lite register bus, decoding the low 12 address bits.
package hcv_pkg;

  // ==========================================================================
  // Register map
  localparam logic [11:0] VERSION_OFS = 12'h000;
  localparam logic [11:0] LOAD_STATUS_OFS = 12'h01C;
  localparam logic [11:0] BIB_BASE_OFS = 12'h020;
  localparam logic [11:0] RXPTR_BASE_OFS = 12'h40C;
  localparam logic [11:0] RXFLT_BASE_OFS = 12'h410;
  localparam logic [11:0] CTX_STRIDE = 12'h020;
  localparam logic [11:0] WORD_STRIDE = 12'h004;
  localparam int CTX_COUNT = 4;

  // ==========================================================================
  // Version word layout
  localparam int PRESENT_BIT = 24;
  localparam int MAJOR_LSB = 16;
  localparam int MINOR_LSB = 0;
  localparam logic [7:0] MAJOR_VERSION = 8'h01;
  localparam logic [7:0] MINOR_VERSION = 8'h00;
  localparam logic [31:0] VERSION_RESET = 32'h00010000;

  // ==========================================================================
  // Detection and loading
  localparam logic [1:0] SETTLE_CYCLES = 2'h2;
  localparam int BIB_WORDS = 4;
  localparam int BYTE_IDX_W = 4;
  localparam logic [3:0] LAST_BYTE = 4'hF;
  localparam int ROM_ADDR_W = 8;

  typedef struct packed {
    logic req;
    logic [ROM_ADDR_W-1:0] addr;
  } hcv_rom_req_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic present;
  } hcv_load_stat_t;

  typedef logic [BIB_WORDS-1:0][31:0] hcv_bib_t;

endpackage

/* File: design/hcv_bib_loader.sv */
// Loader: reads the node information block byte by byte from the serial ROM engine.
// Assumes the engine sits on clk_sys_i and pulses rom_ack_i once per byte while req is held.
`timescale 1ns/100ps
module hcv_bib_loader (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic rom_ack_i,
  input wire logic [7:0] rom_data_i,
  output hcv_pkg::hcv_rom_req_t rom_req_o,
  output hcv_pkg::hcv_bib_t bib_o,
  output logic busy_o,
  output logic done_o
);

  // ==========================================================================
  // State
  typedef enum logic [2:0] {
    HCV_LD_IDLE = 3'b001,
    HCV_LD_READ = 3'b010,
    HCV_LD_DONE = 3'b100
  } hcv_ld_state_t;

  hcv_ld_state_t state, next_state;
  logic [hcv_pkg::BYTE_IDX_W-1:0] byte_idx, next_byte_idx;
  hcv_pkg::hcv_bib_t bib, next_bib;
  logic [1:0] lane;

  always_comb begin
    next_state = state;
    next_byte_idx = byte_idx;
    next_bib = bib;
    lane = 2'(2'h3 - byte_idx[1:0]);
    case (state)
      HCV_LD_IDLE: begin
        if (start_i) begin
          next_state = HCV_LD_READ;
        end
      end
      HCV_LD_READ: begin
        if (rom_ack_i) begin
          // Big-endian quadlets: byte 0 lands in the top lane
          next_bib[byte_idx[3:2]][{lane, 3'h0} +: 8] = rom_data_i;
          next_byte_idx = 4'(byte_idx + 4'h1);
          if (byte_idx == hcv_pkg::LAST_BYTE) begin
            next_state = HCV_LD_DONE;
          end
        end
      end
      HCV_LD_DONE: begin
        next_state = HCV_LD_DONE;
      end
      default: begin
        next_state = HCV_LD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state <= HCV_LD_IDLE;
      byte_idx <= '0;
      bib <= '0;
    end else begin
      state <= next_state;
      byte_idx <= next_byte_idx;
      bib <= next_bib;
    end
  end

  assign rom_req_o.req = (state == HCV_LD_READ);
  assign rom_req_o.addr = hcv_pkg::ROM_ADDR_W'(byte_idx);
  assign bib_o = bib;
  assign busy_o = (state == HCV_LD_READ);
  assign done_o = (state == HCV_LD_DONE);

endmodule // hcv_bib_loader

/* File: design/hcv_regs.sv */
// Version register block with ROM detection, boot load and receive context registers.
// Assumes a single AHB-Lite master and a serial ROM engine on the same clock.
// Contract
// - Version bit 24 reads 1 when the serial ROM was detected, else 0.
// - With ROM present, node information block loads automatically after each hardware reset.
// - Version bits 23-16 always read major version 01h.
// - Version bits 7-0 always read minor version 00h.
// - Version bits 31-25 read zero and hold no state.
// - Version bits 15-8 read zero and hold no state.
// - Version register at 00h, read-only, default 0001 0000h with detection clear.
// - Context pointer at 40Ch+32n, filter at 410h+32n, for n 0 to 3.
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/100ps
module hcv_regs (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic eeprom_detect_i,
  output hcv_pkg::hcv_rom_req_t rom_req_o,
  input wire logic rom_ack_i,
  input wire logic [7:0] rom_data_i,
  output logic load_done_o
);

  // ==========================================================================
  // Detection of the serial ROM
  logic det_sync1, det_sync2, next_det_sync1, next_det_sync2;
  logic [1:0] settle, next_settle;
  logic taken, next_taken;
  logic eeprom_present_flag, next_eeprom_present_flag;
  logic load_start;

  always_comb begin
    next_det_sync1 = eeprom_detect_i;
    next_det_sync2 = det_sync1;
    next_settle = settle;
    next_taken = taken;
    next_eeprom_present_flag = eeprom_present_flag;
    // Pin is caught once after release, never during reset
    if (!taken) begin
      if (settle == hcv_pkg::SETTLE_CYCLES) begin
        next_taken = 1'b1;
        next_eeprom_present_flag = det_sync2;
      end else begin
        next_settle = 2'(settle + 2'h1);
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      det_sync1 <= 1'b0;
      det_sync2 <= 1'b0;
      settle <= 2'h0;
      taken <= 1'b0;
      eeprom_present_flag <= 1'b0;
    end else begin
      det_sync1 <= next_det_sync1;
      det_sync2 <= next_det_sync2;
      settle <= next_settle;
      taken <= next_taken;
      eeprom_present_flag <= next_eeprom_present_flag;
    end
  end

  // ==========================================================================
  // Boot load
  hcv_pkg::hcv_bib_t bib;
  hcv_pkg::hcv_load_stat_t load_stat;

  assign load_start = taken & eeprom_present_flag;

  hcv_bib_loader u_loader (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .start_i(load_start),
    .rom_ack_i(rom_ack_i),
    .rom_data_i(rom_data_i),
    .rom_req_o(rom_req_o),
    .bib_o(bib),
    .busy_o(load_stat.busy),
    .done_o(load_stat.done)
  );

  assign load_stat.present = eeprom_present_flag;
  assign load_done_o = load_stat.done;

  // ==========================================================================
  // Version word
  logic [31:0] version_word;

  always_comb begin
    version_word = '0;
    version_word[hcv_pkg::MAJOR_LSB +: 8] = hcv_pkg::MAJOR_VERSION;
    version_word[hcv_pkg::MINOR_LSB +: 8] = hcv_pkg::MINOR_VERSION;
    version_word[hcv_pkg::PRESENT_BIT] = eeprom_present_flag;
  end

  // ==========================================================================
  // AHB-Lite slave, zero wait states
  logic acc;
  logic wr_pend, next_wr_pend;
  logic [11:0] wr_addr, next_wr_addr;
  logic [11:0] rd_addr;
  logic [hcv_pkg::CTX_COUNT-1:0][31:0] rx_context_descriptor_pointer, next_rx_ptr;
  logic [hcv_pkg::CTX_COUNT-1:0][31:0] rx_context_filter, next_rx_flt;
  logic [31:0] hrdata, next_hrdata, rd_word;

  assign acc = hsel_i & htrans_i[1] & hready_i;
  assign rd_addr = {haddr_i[11:2], 2'h0};

  always_comb begin
    next_rx_ptr = rx_context_descriptor_pointer;
    next_rx_flt = rx_context_filter;
    next_wr_pend = acc & hwrite_i;
    next_wr_addr = rd_addr;
    // Version has no write path at all
    if (wr_pend) begin
      for (int n = 0; n < hcv_pkg::CTX_COUNT; n++) begin
        if (wr_addr == 12'(hcv_pkg::RXPTR_BASE_OFS + hcv_pkg::CTX_STRIDE * n)) begin
          next_rx_ptr[n] = hwdata_i;
        end
        if (wr_addr == 12'(hcv_pkg::RXFLT_BASE_OFS + hcv_pkg::CTX_STRIDE * n)) begin
          next_rx_flt[n] = hwdata_i;
        end
      end
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_word = '0;
    if (rd_addr == hcv_pkg::VERSION_OFS) begin
      rd_word = version_word;
    end
    if (rd_addr == hcv_pkg::LOAD_STATUS_OFS) begin
      rd_word = 32'(load_stat);
    end
    for (int i = 0; i < hcv_pkg::BIB_WORDS; i++) begin
      if (rd_addr == 12'(hcv_pkg::BIB_BASE_OFS + hcv_pkg::WORD_STRIDE * i)) begin
        rd_word = bib[i];
      end
    end
    for (int n = 0; n < hcv_pkg::CTX_COUNT; n++) begin
      if (rd_addr == 12'(hcv_pkg::RXPTR_BASE_OFS + hcv_pkg::CTX_STRIDE * n)) begin
        rd_word = next_rx_ptr[n];
      end
      if (rd_addr == 12'(hcv_pkg::RXFLT_BASE_OFS + hcv_pkg::CTX_STRIDE * n)) begin
        rd_word = next_rx_flt[n];
      end
    end
  end

  // Reads only load the data register, so they disturb nothing else
  always_comb begin
    next_hrdata = hrdata;
    if (acc & ~hwrite_i) begin
      next_hrdata = rd_word;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
      rx_context_descriptor_pointer <= '0;
      rx_context_filter <= '0;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      rx_context_descriptor_pointer <= next_rx_ptr;
      rx_context_filter <= next_rx_flt;
      hrdata <= next_hrdata;
    end
  end

  assign hrdata_o = hrdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  // ==========================================================================
  // Checks
  logic ver_rd;
  assign ver_rd = acc & ~hwrite_i & (rd_addr == hcv_pkg::VERSION_OFS);

  chk_present_bit: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ver_rd |=> hrdata_o[24] == $past(eeprom_present_flag))
    else $error("version detect bit wrong");
  chk_load_start: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(taken) && eeprom_present_flag |-> ##1 rom_req_o.req)
    else $error("boot load did not start");
  chk_major_field: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ver_rd |=> hrdata_o[23:16] == 8'h01)
    else $error("major version wrong");
  chk_minor_field: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ver_rd |=> hrdata_o[7:0] == 8'h00)
    else $error("minor version wrong");
  chk_rsvd_high: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ver_rd |=> hrdata_o[31:25] == 7'h00)
    else $error("upper reserved bits not zero");
  chk_rsvd_mid: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ver_rd |=> hrdata_o[15:8] == 8'h00)
    else $error("middle reserved bits not zero");
  chk_reset_value: assert property (@(posedge clk_sys_i)
    $past(rst_i) && !rst_i |-> version_word == 32'h00010000 ##1 !taken)
    else $error("version default wrong after reset");
  chk_ctx_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_pend && wr_addr == 12'h46C |=> rx_context_descriptor_pointer[3] == $past(hwdata_i))
    else $error("context pointer write lost");
  chk_flt_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_pend && wr_addr == 12'h410 |=> rx_context_filter[0] == $past(hwdata_i))
    else $error("context filter write lost");
  chk_ver_nowrite: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_pend && wr_addr == 12'h000 |=> $stable(rx_context_descriptor_pointer)
      && $stable(rx_context_filter) && $stable(eeprom_present_flag))
    else $error("version write changed state");

  cov_ver_present: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    ver_rd ##1 hrdata_o[24]);
  cov_load_done: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(load_done_o));
  cov_ctx_write: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_pend && wr_addr == 12'h42C);
  cov_wr_then_rd: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_pend && acc && !hwrite_i && rd_addr == wr_addr);

endmodule // hcv_regs

/* File: tb/hcv_regs_bench.sv */
// Bench: version register reads and writes over AHB-Lite, serial ROM boot load, reset.
// Assumes a zero-wait slave; the bench itself plays the ROM engine and the bus master.
`timescale 1ns/100ps
module host_controller_version_regs_bench;
  typedef struct packed {
    logic wr;
    logic [31:0] addr;
    logic [31:0] data;
  } hcv_row_t;
  // ==========================================================================
  // Signals
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic strap = 1'b1;
  logic rom_ack = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [7:0] rom_data = 8'h00;
  logic hready;
  logic hresp;
  logic load_done;
  hcv_pkg::hcv_rom_req_t rom_req;
  int mismatches = 0;
  int samples_checked = 0;
  // Writes to read-only places come back unchanged on the next row
  localparam hcv_row_t ROWS [12] = '{
    '{1'b0, 32'h000, 32'h01010000}, '{1'b1, 32'h000, 32'hFFFFFFFF},
    '{1'b0, 32'h000, 32'h01010000}, '{1'b0, 32'h01C, 32'h00000003},
    '{1'b0, 32'h020, 32'h00112233}, '{1'b0, 32'h024, 32'h44556677},
    '{1'b0, 32'h028, 32'h8899AABB}, '{1'b0, 32'h02C, 32'hCCDDEEFF},
    '{1'b1, 32'h400, 32'h12345678}, '{1'b0, 32'h400, 32'h00000000},
    '{1'b1, 32'h020, 32'hFFFFFFFF}, '{1'b0, 32'h020, 32'h00112233}};

  always #2.5 clk_sys_i = ~clk_sys_i;

  hcv_regs u_dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hready_i(hready),
    .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .eeprom_detect_i(strap), .rom_req_o(rom_req), .rom_ack_i(rom_ack),
    .rom_data_i(rom_data), .load_done_o(load_done));

  // ==========================================================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) begin
      mismatches++;
      close_out;
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready;
    r = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask

  task automatic do_reset(input logic s);
    strap <= s;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
  endtask

  // ==========================================================================
  // Sequence
  initial begin
    int n;
    do_reset(1'b1);
    // Detection not yet captured at the first read
    bus(1'b0, 32'h000, 32'h0, rd);
    check(rd, hcv_pkg::VERSION_RESET);
    $display("reset default done");
    n = 0;
    do begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end while (rom_req.req !== 1'b1 && n < 20);
    check({23'h0, rom_req}, 32'h100);
    // Load never started: mismatch already counted, stop here
    if (rom_req.req !== 1'b1) close_out;
    @(posedge clk_sys_i);
    rom_ack <= 1'b1;
    rom_data <= 8'h00;
    // Back-to-back acks, one byte each
    for (int k = 1; k <= 16; k++) begin
      @(posedge clk_sys_i);
      if (k < 16) rom_data <= 8'(k * 17);
      else rom_ack <= 1'b0;
      #1;
      if (k < 16) check({23'h0, rom_req}, 32'h100 + k);
      else check({30'h0, rom_req.req, load_done}, 32'h1);
    end
    $display("boot load done");
    foreach (ROWS[i]) begin
      bus(ROWS[i].wr, ROWS[i].addr, ROWS[i].data, rd);
      if (!ROWS[i].wr) check(rd, ROWS[i].data);
    end
    $display("table done");
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 32'h40C + 32 * c, 32'hC0DE0000 | c, rd);
      bus(1'b1, 32'h410 + 32 * c, 32'hF17E0000 | c, rd);
    end
    for (int c = 0; c < 4; c++) begin
      bus(1'b0, 32'h40C + 32 * c, 32'h0, rd);
      check(rd, 32'hC0DE0000 | c);
      bus(1'b0, 32'h410 + 32 * c, 32'h0, rd);
      check(rd, 32'hF17E0000 | c);
    end
    // Read right behind a write takes the forwarded word
    haddr <= 32'h42C;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    wait_ready;
    hwrite <= 1'b0;
    hwdata <= 32'h5A5A0000;
    wait_ready;
    htrans <= 2'h0;
    wait_ready;
    check(hrdata, 32'h5A5A0000);
    $display("context map done");
    // Second reset with no ROM: no load may start
    do_reset(1'b0);
    repeat (10) @(posedge clk_sys_i);
    check({30'h0, rom_req.req, load_done}, 32'h0);
    bus(1'b0, 32'h000, 32'h0, rd);
    check(rd, 32'h00010000);
    bus(1'b0, 32'h020, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b0, 32'h40C, 32'h0, rd);
    check(rd, 32'h0);
    $display("absent rom done");
    close_out;
  end
endmodule // host_controller_version_regs_bench
